// file: rtl/pfi_top.v
// Interrupt mask, status registers and open-drain interrupt pin
`timescale 1ns/1ps
`include "pfi_defs.vh"
`default_nettype none
module pfi_top #(
  parameter TEMP_W = 8,
  parameter BIAS_W = 9,
  parameter [8:0] BIAS_LOW_LIMIT = 9'h000,
  parameter [8:0] BIAS_HIGH_LIMIT = 9'h1FF
) (
  input wire clk_in,
  input wire rst_n_in,
  // Register port from the serial interface engine
  input wire [7:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  output reg reg_rvalid_out,
  // Temperature converter
  input wire conv_done_in,
  input wire [TEMP_W-1:0] panel_temp_in,
  // Thermal and supply monitors
  input wire thermal_shutdown_in,
  input wire hot_warning_in,
  input wire [TEMP_W-1:0] thermistor_temp_in,
  input wire [TEMP_W-1:0] hot_limit_in,
  input wire [TEMP_W-1:0] cold_limit_in,
  input wire input_uv_in,
  // Backplane bias engine
  input wire bias_measure_done_in,
  input wire bias_program_done_in,
  input wire [BIAS_W-1:0] bias_level_in,
  // Rail undervoltage comparators
  input wire boost_uv_in,
  input wire gate_high_uv_in,
  input wire inverter_uv_in,
  input wire pos_source_uv_in,
  input wire gate_low_uv_in,
  input wire neg_source_uv_in,
  // Open-drain interrupt pin
  input wire irq_out_n_in,
  output reg irq_out_n_out,
  output reg irq_out_n_oe_out
);
  // Register state
  reg [7:0] mask_one_reg;
  reg [7:0] mask_two_reg;
  reg [7:0] mask_one_next;
  reg [7:0] mask_two_next;
  reg [7:0] rdata_next;

  // Status assembly
  wire temp_change_evt;
  wire [7:0] status_one;
  wire [7:0] status_two;
  wire [7:0] sticky_two_set;
  wire [7:0] sticky_two_q;
  wire [2:0] sticky_one_set;
  wire [2:0] sticky_one_q;
  wire [7:0] pending;
  wire thermistor_high_flag;
  wire thermistor_low_flag;
  wire bias_fault_flag;
  wire rd_status_one;
  wire rd_status_two;

  // Register access decode
  assign rd_status_one = reg_rd_in && (reg_addr_in == `PFI_ADDR_STATUS_ONE);
  assign rd_status_two = reg_rd_in && (reg_addr_in == `PFI_ADDR_STATUS_TWO);

  // Temperature change is judged on each new conversion result
  pfi_temp_delta #(
    .TEMP_W(TEMP_W)
  ) u_temp_delta (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .sample_in(conv_done_in),
    .temp_in(panel_temp_in),
    .change_out(temp_change_evt)
  );

  // Thermistor limits compared signed, inclusive at both ends
  assign thermistor_high_flag = $signed(thermistor_temp_in) >= $signed(hot_limit_in);
  assign thermistor_low_flag = $signed(thermistor_temp_in) <= $signed(cold_limit_in);

  // Bias fault is any level outside the configured window
  assign bias_fault_flag = (bias_level_in < BIAS_LOW_LIMIT) ||
                           (bias_level_in > BIAS_HIGH_LIMIT);

  // Event sources of status one that must be held until read
  assign sticky_one_set[2] = temp_change_evt;
  assign sticky_one_set[1] = bias_measure_done_in;
  assign sticky_one_set[0] = bias_program_done_in;

  // Status two sources; all latched so a short glitch is still seen
  assign sticky_two_set[`PFI_S2_BOOST_UV] = boost_uv_in;
  assign sticky_two_set[`PFI_S2_GATE_HIGH_UV] = gate_high_uv_in;
  assign sticky_two_set[`PFI_S2_INVERTER_UV] = inverter_uv_in;
  assign sticky_two_set[`PFI_S2_POS_SOURCE_UV] = pos_source_uv_in;
  assign sticky_two_set[`PFI_S2_GATE_LOW_UV] = gate_low_uv_in;
  assign sticky_two_set[`PFI_S2_BIAS_FAULT] = bias_fault_flag;
  assign sticky_two_set[`PFI_S2_NEG_SOURCE_UV] = neg_source_uv_in;
  assign sticky_two_set[`PFI_S2_CONV_DONE] = conv_done_in;

  // Completion flags of status one; a read acknowledges only bits it returned
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sticky_one
      pfi_flag_cell u_cell (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .set_in(sticky_one_set[gi]),
        .clr_in(rd_status_one && sticky_one_q[gi]),
        .flag_out(sticky_one_q[gi])
      );
    end
  endgenerate

  // Status two flags; a fault still present re-sets its flag over the read
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_sticky_two
      pfi_flag_cell u_cell (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .set_in(sticky_two_set[gi]),
        .clr_in(rd_status_two && sticky_two_q[gi]),
        .flag_out(sticky_two_q[gi])
      );
    end
  endgenerate

  // Status one: live thermal and supply levels beside held completions
  assign status_one[`PFI_S1_TEMP_CHANGE] = sticky_one_q[2];
  assign status_one[`PFI_S1_SHUTDOWN] = thermal_shutdown_in;
  assign status_one[`PFI_S1_HOT] = hot_warning_in;
  assign status_one[`PFI_S1_THERM_HIGH] = thermistor_high_flag;
  assign status_one[`PFI_S1_THERM_LOW] = thermistor_low_flag;
  assign status_one[`PFI_S1_INPUT_UV] = input_uv_in;
  assign status_one[`PFI_S1_MEASURE_DONE] = sticky_one_q[1];
  assign status_one[`PFI_S1_PROGRAM_DONE] = sticky_one_q[0];
  assign status_two = sticky_two_q;

  // Mask register writes; status addresses ignore writes
  always @*
  begin
    mask_one_next = mask_one_reg;
    mask_two_next = mask_two_reg;
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        `PFI_ADDR_MASK_ONE:
          // Read-only bits keep their fixed values
          mask_one_next = (reg_wdata_in & `PFI_MASK_ONE_WR) |
                          (mask_one_reg & ~`PFI_MASK_ONE_WR);
        `PFI_ADDR_MASK_TWO:
          mask_two_next = reg_wdata_in;
        default:
          mask_two_next = mask_two_reg;
      endcase
    end
  end

  // Read mux; other addresses belong to neighbouring blocks and read zero here
  always @*
  begin
    case (reg_addr_in)
      `PFI_ADDR_MASK_ONE: rdata_next = mask_one_reg;
      `PFI_ADDR_MASK_TWO: rdata_next = mask_two_reg;
      `PFI_ADDR_STATUS_ONE: rdata_next = status_one;
      `PFI_ADDR_STATUS_TWO: rdata_next = status_two;
      default: rdata_next = `PFI_UNMAPPED_DATA;
    endcase
  end

  // Masks reset to enabled so every source except temperature change (mask one bit 7, fixed at zero) can interrupt after power-up
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mask_one_reg <= `PFI_MASK_ONE_RESET;
      mask_two_reg <= `PFI_MASK_TWO_RESET;
    end
    else
    begin
      mask_one_reg <= mask_one_next;
      mask_two_reg <= mask_two_next;
    end
  end

  // Read data is captured with the read strobe, one cycle of latency
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      reg_rdata_out <= `PFI_STATUS_RESET;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in)
        reg_rdata_out <= rdata_next;
    end
  end

  // Any enabled pending flag asks for service
  assign pending = (status_one & mask_one_reg) | (status_two & mask_two_reg);

  // Open drain: only ever drives low, otherwise releases to the pull-up
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      irq_out_n_out <= 1'b0;
      irq_out_n_oe_out <= 1'b0;
    end
    else
    begin
      irq_out_n_out <= 1'b0;
      irq_out_n_oe_out <= |pending;
    end
  end
endmodule // pfi_top
`default_nettype wire

// file: rtl/pfi_defs.vh
// Constants for the fault interrupt enable and status logic
// Function
// - An enabled source's event pulls the interrupt pin low; a disabled one leaves it.
// - Mask two: eight read-write bits, reset enabled; bits 7..3 mask rail undervoltages.
// - Second mask bits 2,1,0 mask bias fault, negative source UV, conversion done; reset enabled.
// - Status one bit 7 sets on a temperature change of three degrees or more.
// - Status one bit 6 reads one while the chip is in thermal shutdown.
// - Status one bit 5 reads one while the chip approaches thermal shutdown.
// - Status one bit 4 sets when thermistor temperature is at or above hot limit.
// - Status one bit 3 sets when thermistor temperature is at or below cold limit.
// - Status one bit 2 sets while input voltage is below the lockout threshold.
// - Status one bit 1 sets when a bias measurement finishes; resets to zero.
// - Status one bit 0 sets when bias programming finishes; resets to zero.
// - Status two bit 7 sets on boost converter undervoltage.
// - Status two bit 6 sets on gate-high charge pump undervoltage.
// - Status two bit 5 sets on inverting converter undervoltage.
// - Status two bit 4 sets on positive source regulator undervoltage.
// - Status two bit 3 sets on gate-low charge pump undervoltage.
// - Status two bit 1 sets on negative source regulator undervoltage.
// - Status two bit 0 sets when a temperature conversion completes.
// - Status one sits at 0x07, status two at 0x08; both are read-only.
// - Second mask register sits at 0x06 and resets to all ones.
// - First mask at 0x05 mirrors status one; bits 7,1,0 are read-only.
`ifndef PFI_DEFS_VH
`define PFI_DEFS_VH

// Register addresses
`define PFI_ADDR_MASK_ONE 8'h05
`define PFI_ADDR_MASK_TWO 8'h06
`define PFI_ADDR_STATUS_ONE 8'h07
`define PFI_ADDR_STATUS_TWO 8'h08

// Reset values and writable fields
`define PFI_MASK_ONE_RESET 8'h7F
`define PFI_MASK_ONE_WR 8'h7C
`define PFI_MASK_TWO_RESET 8'hFF
`define PFI_STATUS_RESET 8'h00
`define PFI_UNMAPPED_DATA 8'h00

// Status one bit positions
`define PFI_S1_TEMP_CHANGE 7
`define PFI_S1_SHUTDOWN 6
`define PFI_S1_HOT 5
`define PFI_S1_THERM_HIGH 4
`define PFI_S1_THERM_LOW 3
`define PFI_S1_INPUT_UV 2
`define PFI_S1_MEASURE_DONE 1
`define PFI_S1_PROGRAM_DONE 0

// Status two bit positions
`define PFI_S2_BOOST_UV 7
`define PFI_S2_GATE_HIGH_UV 6
`define PFI_S2_INVERTER_UV 5
`define PFI_S2_POS_SOURCE_UV 4
`define PFI_S2_GATE_LOW_UV 3
`define PFI_S2_BIAS_FAULT 2
`define PFI_S2_NEG_SOURCE_UV 1
`define PFI_S2_CONV_DONE 0

// Temperature change threshold in degrees
`define PFI_TEMP_DELTA_DEG 9'h003

`endif

// file: rtl/pfi_flag_cell.v
// Sticky event flag with set priority over acknowledge
`timescale 1ns/1ps
`default_nettype none
module pfi_flag_cell (
  input wire clk_in,
  input wire rst_n_in,
  input wire set_in,
  input wire clr_in,
  output reg flag_out
);
  // A set in the acknowledge cycle survives, so no event is lost
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      flag_out <= 1'b0;
    else if (set_in)
      flag_out <= 1'b1;
    else if (clr_in)
      flag_out <= 1'b0;
  end
endmodule // pfi_flag_cell
`default_nettype wire

// file: rtl/pfi_temp_delta.v
// Detects a temperature change of the set threshold against the previous reading
`timescale 1ns/1ps
`include "pfi_defs.vh"
`default_nettype none
module pfi_temp_delta #(
  parameter TEMP_W = 8
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire sample_in,
  input wire [TEMP_W-1:0] temp_in,
  output reg change_out
);
  reg [TEMP_W-1:0] prev_reg;
  reg have_prev_reg;
  wire signed [TEMP_W:0] diff;
  wire [TEMP_W:0] mag;

  // Signed difference, one bit wider so it cannot wrap
  assign diff = {temp_in[TEMP_W-1], temp_in} - {prev_reg[TEMP_W-1], prev_reg};
  assign mag = diff[TEMP_W] ? (~diff + 1'b1) : diff;

  // The first reading after reset has nothing to compare against
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prev_reg <= {TEMP_W{1'b0}};
      have_prev_reg <= 1'b0;
      change_out <= 1'b0;
    end
    else
    begin
      change_out <= sample_in && have_prev_reg && (mag >= `PFI_TEMP_DELTA_DEG);
      if (sample_in)
      begin
        prev_reg <= temp_in;
        have_prev_reg <= 1'b1;
      end
    end
  end
endmodule // pfi_temp_delta
`default_nettype wire

// file: testbench/pfi_top_checker.sv
// Port assertions for the fault interrupt block
`timescale 1ns/1ps
`default_nettype none
module pfi_top_checker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic conv_done_in,
  input wire logic thermal_shutdown_in,
  input wire logic boost_uv_in,
  input wire logic gate_high_uv_in,
  input wire logic inverter_uv_in,
  input wire logic pos_source_uv_in,
  input wire logic gate_low_uv_in,
  input wire logic neg_source_uv_in,
  input wire logic irq_out_n_out,
  input wire logic irq_out_n_oe_out
);
  // Sources that could set status two again; bias fault is left out, so bit 2 is not judged
  wire s2_quiet = !(|{boost_uv_in, gate_high_uv_in, inverter_uv_in, pos_source_uv_in,
    gate_low_uv_in, neg_source_uv_in, conv_done_in});
  wire rd_s2 = reg_rd_in && reg_addr_in == 8'h08;
  // Mirror of the shutdown enable, from its reset value and the host's writes
  logic shutdown_en_reg;
  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      shutdown_en_reg <= 1'b1;
    else if (reg_wr_in && reg_addr_in == 8'h05)
      shutdown_en_reg <= reg_wdata_in[6];
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_rvalid; reg_rd_in |=> reg_rvalid_out; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid missing");
  property p_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_unmap;
    reg_rd_in && (reg_addr_in < 8'h05 || reg_addr_in > 8'h08) |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_m1ro;
    reg_rd_in && reg_addr_in == 8'h05 |=> reg_rdata_out[7] == 1'b0 && reg_rdata_out[1:0] == 2'b11;
  endproperty
  a_m1ro: assert property (p_m1ro) else $error("fixed mask bits wrong");
  property p_m2rw;
    reg_wr_in && reg_addr_in == 8'h06 ##1 !reg_wr_in ##1 reg_rd_in && reg_addr_in == 8'h06
      |=> reg_rdata_out == $past(reg_wdata_in, 3);
  endproperty
  a_m2rw: assert property (p_m2rw) else $error("mask two readback differs");
  property p_tsd;
    reg_rd_in && reg_addr_in == 8'h07 && thermal_shutdown_in |=> reg_rdata_out[6];
  endproperty
  a_tsd: assert property (p_tsd) else $error("shutdown flag not read");
  property p_boost; boost_uv_in ##1 (!rd_s2) [*4] ##1 rd_s2 |=> reg_rdata_out[7]; endproperty
  a_boost: assert property (p_boost) else $error("boost flag lost");
  property p_clr;
    rd_s2 && s2_quiet ##1 s2_quiet ##1 rd_s2 && s2_quiet |=> (reg_rdata_out & 8'hFB) == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("status two not cleared by read");
  property p_od; !irq_out_n_out; endproperty
  a_od: assert property (p_od) else $error("pin data not low");
  property p_tsd_pin; thermal_shutdown_in && shutdown_en_reg |=> irq_out_n_oe_out; endproperty
  a_tsd_pin: assert property (p_tsd_pin) else $error("shutdown pin not driven");
endmodule // pfi_top_checker
bind pfi_top pfi_top_checker u_pfi_top_checker (.clk_in, .rst_n_in, .reg_addr_in, .reg_wr_in,
  .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .conv_done_in,
  .thermal_shutdown_in, .boost_uv_in, .gate_high_uv_in, .inverter_uv_in, .pos_source_uv_in,
  .gate_low_uv_in, .neg_source_uv_in, .irq_out_n_out, .irq_out_n_oe_out);
`default_nettype wire

// file: testbench/pfi_host.sv
// Host model: register strobes and the pulled-up interrupt line
`timescale 1ns/1ps
`default_nettype none
module pfi_host (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic oe_in,
  input wire logic od_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out,
  output wire logic irq_n_out
);
  // Board pull-up holds the line high whenever the device lets go
  assign irq_n_out = oe_in ? od_in : 1'b1;
  // Bus idle from time zero
  initial
  begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  // One write strobe cycle
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask
  // Read strobe; data lands just after the edge that takes it
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1;
    d = rdata_in;
  endtask
endmodule // pfi_host
`default_nettype wire

// file: testbench/pfi_top_tb.sv
// Self-checking bench for the fault interrupt block
`timescale 1ns/1ps
`default_nettype none
module pfi_top_tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] src = 8'h00;
  logic [4:0] lvl = 5'h00;
  logic [1:0] done = 2'b00;
  logic [7:0] panel = 8'h00;
  logic [7:0] v;
  logic [7:0] d;
  logic [7:0] a;
  wire [7:0] addr, wdata, rdata;
  wire wr, rd, rvalid, od, oe, irq_n;
  integer seed = 95355;
  integer error_cnt = 0;
  integer n_compared = 0;
  integer i, k, dl;
  // Bias sits in range except while its source bit pulses
  pfi_top #(.BIAS_LOW_LIMIT(9'h010), .BIAS_HIGH_LIMIT(9'h1F0)) u_pfi_top (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .conv_done_in(src[0]), .panel_temp_in(panel), .thermal_shutdown_in(lvl[0]),
    .hot_warning_in(lvl[1]), .thermistor_temp_in(lvl[2] ? 8'h32 : lvl[3] ? 8'hF6 : 8'h14),
    .hot_limit_in(8'h32), .cold_limit_in(8'hF6), .input_uv_in(lvl[4]),
    .bias_measure_done_in(done[0]), .bias_program_done_in(done[1]),
    .bias_level_in(src[2] ? 9'h1F5 : 9'h100), .boost_uv_in(src[7]), .gate_high_uv_in(src[6]),
    .inverter_uv_in(src[5]), .pos_source_uv_in(src[4]), .gate_low_uv_in(src[3]),
    .neg_source_uv_in(src[1]), .irq_out_n_in(irq_n), .irq_out_n_out(od),
    .irq_out_n_oe_out(oe));
  pfi_host u_pfi_host (.clk_in(clk_in), .rdata_in(rdata), .oe_in(oe), .od_in(od),
    .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata), .irq_n_out(irq_n));
  // 250 MHz clock
  initial forever #2 clk_in = ~clk_in;
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("wrong value %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task pin(input logic e);
    chk("irq", {7'h00, irq_n}, {7'h00, e});
  endtask
  // Strobe event sources for one cycle, then let flags and pin settle
  task pulse(input logic [7:0] s);
    @(posedge clk_in);
    src <= s;
    @(posedge clk_in);
    src <= 8'h00;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  // Readback of a write: only mask bits 6..2 of mask one move, status ignores writes
  function logic [7:0] exp_reg(input logic [7:0] ad, input logic [7:0] w);
    return ad == 8'h06 ? w : ad == 8'h05 ? ((w & 8'h7C) | 8'h03) : 8'h00;
  endfunction
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #40000;
    error_cnt = error_cnt + 1;
    stop_test;
  end
  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (k = 0; k < 4; k = k + 1)
    begin
      u_pfi_host.rd(8'h05 + k[7:0], d);
      chk("reset", d, k == 0 ? 8'h7F : k == 1 ? 8'hFF : 8'h00);
    end
    pin(1'b1);
    // Random writes to every place, an unmapped one last
    for (k = 0; k < 5; k = k + 1)
    begin
      a = k == 4 ? 8'h20 : 8'h05 + k[7:0];
      v = $random(seed);
      u_pfi_host.wr(a, v);
      u_pfi_host.rd(a, d);
      chk("access", d, exp_reg(a, v));
    end
    u_pfi_host.wr(8'h05, 8'hFF);
    $display("test registers done");
    // Each status two source masked, then enabled and acknowledged
    for (i = 0; i < 8; i = i + 1)
    begin
      u_pfi_host.wr(8'h06, 8'h00);
      pulse(8'h01 << i);
      pin(1'b1);
      u_pfi_host.rd(8'h08, d);
      chk("stat2", d, 8'h01 << i);
      u_pfi_host.wr(8'h06, 8'h01 << i);
      pulse(8'h01 << i);
      pin(1'b0);
      u_pfi_host.rd(8'h08, d);
      chk("stat2", d, 8'h01 << i);
      u_pfi_host.rd(8'h08, d);
      chk("stat2 ack", d, 8'h00);
      pin(1'b1);
    end
    $display("test status two done");
    // Live conditions, thermistor exactly at each limit
    for (k = 0; k < 5; k = k + 1)
    begin
      @(posedge clk_in);
      lvl <= 5'h01 << k;
      repeat (2) @(posedge clk_in);
      #1;
      pin(1'b0);
      u_pfi_host.rd(8'h07, d);
      chk("stat1", d, 8'h40 >> k);
      @(posedge clk_in);
      lvl <= 5'h00;
      repeat (2) @(posedge clk_in);
      #1;
      pin(1'b1);
    end
    // Bias completion flags stick until read
    for (k = 0; k < 2; k = k + 1)
    begin
      @(posedge clk_in);
      done <= 2'b01 << k;
      @(posedge clk_in);
      done <= 2'b00;
      u_pfi_host.rd(8'h07, d);
      chk("done", d, 8'h02 >> k);
      u_pfi_host.rd(8'h07, d);
      chk("done ack", d, 8'h00);
    end
    $display("test status one done");
    // Steps of +3, -3, +2, -2 at the threshold, then random steps
    for (k = 0; k < 10; k = k + 1)
    begin
      dl = k < 4 ? (k % 2 == 1 ? -1 : 1) * (3 - k / 2) : $random(seed) % 6;
      @(posedge clk_in);
      src <= 8'h01;
      panel <= panel + dl[7:0];
      @(posedge clk_in);
      src <= 8'h00;
      u_pfi_host.rd(8'h07, d);
      chk("temp change", d, (dl >= 3 || dl <= -3) ? 8'h80 : 8'h00);
    end
    $display("test temperature change done");
    stop_test;
  end
endmodule // pfi_top_tb
`default_nettype wire
